/* File: rtl/ssdb_map.svh */
`ifndef SSDB_MAP_SVH
`define SSDB_MAP_SVH
`define SSDB_RESP_CURRENT 7'h70
`define SSDB_ADD_LEN      8'h0a
`define SSDB_SENSE_LEN    5'h12
`define SSDB_IDX_RESP     5'h00
`define SSDB_IDX_KEY      5'h02
`define SSDB_IDX_INFO0    5'h03
`define SSDB_IDX_INFO3    5'h06
`define SSDB_IDX_ADDLEN   5'h07
`define SSDB_IDX_RSV0     5'h08
`define SSDB_IDX_RSV3     5'h0b
`define SSDB_IDX_ASC      5'h0c
`define SSDB_IDX_QUAL     5'h0d
`define SSDB_IDX_FRU      5'h0e
`define SSDB_IDX_KSPEC    5'h0f
`define SSDB_IDX_KSPEC_HI 5'h10
`define SSDB_IDX_KSPEC_LO 5'h11
`define SSDB_KEY_RECOVERED 4'h1
`define SSDB_KEY_MEDIUM    4'h3
`define SSDB_KEY_HARDWARE  4'h4
`define SSDB_KEY_ILLEGAL   4'h5
`define SSDB_ASC_NONE      8'h00
`define SSDB_ASC_RESERVED  8'h01
`define SSDB_ASC_SEEK      8'h02
`define SSDB_ASC_WFAULT    8'h03
`define SSDB_ASC_NREADY    8'h04
`define SSDB_ASC_NOSEL     8'h05
`define SSDB_ASC_NOREF     8'h06
`define SSDB_ASC_COMM      8'h08
`define SSDB_ASC_HDRCHK    8'h10
`define SSDB_ASC_UNREAD    8'h11
`define SSDB_ASC_HDRMARK   8'h12
`define SSDB_ASC_DATAMARK  8'h13
`define SSDB_ASC_MISSING   8'h14
`define SSDB_ASC_CYLMIS    8'h15
`define SSDB_ASC_SYNCMARK  8'h16
`define SSDB_ASC_RECRETRY  8'h17
`define SSDB_ASC_RECECC    8'h18
`define SSDB_ASC_DEFLIST   8'h19
`define SSDB_ASC_PLISTLEN  8'h1a
`define SSDB_ASC_SYNCXFER  8'h1b
`define SSDB_RETRY_MAX     16'hffff
`define SSDB_RETRY_ONE     16'h0001
`endif

/* File: rtl/ssdb_pkg.sv */
package ssdb_pkg;
  typedef enum logic [4:0] {
    COND_NONE, COND_SEEK, COND_WRITE_FAULT, COND_NOT_READY, COND_NO_SELECT,
    COND_NO_REF_POS, COND_UNIT_COMM, COND_HDR_CHECK, COND_UNRECOV_READ,
    COND_HDR_MARK, COND_DATA_MARK, COND_BLOCK_MISSING, COND_CYL_MISMATCH,
    COND_SYNC_MARK, COND_RECOV_RETRY, COND_RECOV_ECC, COND_DEFECT_LIST,
    COND_PARAM_LEN, COND_SYNC_XFER
  } ssdb_cond_t;

  typedef struct packed {
    logic        info_valid;
    logic        ili;
    logic [3:0]  key;
    logic [31:0] info;
    ssdb_cond_t  cond;
    logic [7:0]  qualifier;
    logic [7:0]  replaceable_unit_code;
    logic        ptr_req;
    logic        cd;
    logic        bit_ptr_req;
    logic [2:0]  bit_ptr;
    logic [15:0] field_ptr;
  } ssdb_event_t;

  typedef struct packed {
    logic [7:0] data;
    logic [4:0] index;
    logic       last;
  } ssdb_byte_t;
endpackage

/* File: rtl/ssdb_asc_enc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssdb_map.svh"
module ssdb_asc_enc (
  // Condition in
  input  wire ssdb_pkg::ssdb_cond_t cond,
  // Code out
  output logic [7:0]                asc
);
  import ssdb_pkg::*;

  always_comb begin
    unique case (cond)
      COND_NONE:          asc = `SSDB_ASC_NONE;
      COND_SEEK:          asc = `SSDB_ASC_SEEK;
      COND_WRITE_FAULT:   asc = `SSDB_ASC_WFAULT;
      COND_NOT_READY:     asc = `SSDB_ASC_NREADY;
      COND_NO_SELECT:     asc = `SSDB_ASC_NOSEL;
      COND_NO_REF_POS:    asc = `SSDB_ASC_NOREF;
      COND_UNIT_COMM:     asc = `SSDB_ASC_COMM;
      COND_HDR_CHECK:     asc = `SSDB_ASC_HDRCHK;
      COND_UNRECOV_READ:  asc = `SSDB_ASC_UNREAD;
      COND_HDR_MARK:      asc = `SSDB_ASC_HDRMARK;
      COND_DATA_MARK:     asc = `SSDB_ASC_DATAMARK;
      COND_BLOCK_MISSING: asc = `SSDB_ASC_MISSING;
      COND_CYL_MISMATCH:  asc = `SSDB_ASC_CYLMIS;
      COND_SYNC_MARK:     asc = `SSDB_ASC_SYNCMARK;
      COND_RECOV_RETRY:   asc = `SSDB_ASC_RECRETRY;
      COND_RECOV_ECC:     asc = `SSDB_ASC_RECECC;
      COND_DEFECT_LIST:   asc = `SSDB_ASC_DEFLIST;
      COND_PARAM_LEN:     asc = `SSDB_ASC_PLISTLEN;
      COND_SYNC_XFER:     asc = `SSDB_ASC_SYNCXFER;
      // Unused codes fall to zero, so 01 never appears
      default:            asc = `SSDB_ASC_NONE;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/ssdb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssdb_map.svh"
module ssdb_top (
  // Clock and reset
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_N,
  // Command progress
  input  wire logic                 CMD_START,
  input  wire logic                 RETRY_STEP,
  input  wire logic [15:0]          RETRY_LIMIT,
  output logic                      RETRY_EXHAUSTED,
  // Event capture
  input  wire logic                 EVT_LOAD,
  input  wire ssdb_pkg::ssdb_event_t EVT,
  output logic                      EVT_READY,
  // Sense request
  input  wire logic                 REQ_START,
  input  wire logic [7:0]           ALLOC_LEN,
  output logic                      REQ_BUSY,
  output logic                      REQ_DONE,
  // Byte stream
  output logic                      BYTE_VALID,
  input  wire logic                 BYTE_READY,
  output ssdb_pkg::ssdb_byte_t      BYTE_OUT,
  // Status
  output logic [7:0]                SENSE_ASC,
  output logic                      POINTER_VALID_FLAG
);
  import ssdb_pkg::*;

  typedef enum logic {S_IDLE, S_SEND} ssdb_state_t;

  logic        rst_meta;
  logic        rst_n;
  ssdb_state_t state;
  logic [15:0] retry_count;
  logic [7:0]  enc_asc;
  logic        take_evt;
  logic        take_req;
  logic        advance;
  logic [4:0]  limit;
  logic [4:0]  next_limit;
  logic [4:0]  next_index;

  // Snapshot of the reported event
  logic        snap_info_valid;
  logic        snap_ili;
  logic [3:0]  snap_key;
  logic [31:0] snap_info;
  logic [7:0]  snap_asc;
  logic [7:0]  snap_qual;
  logic [7:0]  snap_unit;
  logic        pointer_valid_flag;
  logic        snap_cd;
  logic        bit_pointer_valid_flag;
  logic [2:0]  snap_bit_ptr;
  logic [15:0] snap_field_ptr;
  logic        key_specific_valid;
  logic [15:0] snap_retry;

  // Reset release through two stages; assertion stays asynchronous
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ssdb_asc_enc u_enc (
    .cond (EVT.cond),
    .asc  (enc_asc)
  );

  // Loads are refused while a transfer runs so the bytes never tear
  assign EVT_READY = (state == S_IDLE) && !REQ_START;
  assign take_evt  = EVT_LOAD && EVT_READY;
  assign take_req  = REQ_START && (state == S_IDLE);
  assign advance   = BYTE_VALID && BYTE_READY;
  assign REQ_BUSY  = (state == S_SEND);
  assign BYTE_VALID = (state == S_SEND);

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      retry_count <= '0;
    end else if (CMD_START) begin
      retry_count <= RETRY_STEP ? `SSDB_RETRY_ONE : '0;
    end else if (RETRY_STEP && retry_count != `SSDB_RETRY_MAX) begin
      retry_count <= retry_count + `SSDB_RETRY_ONE;
    end
  end

  // Flags hitting the configured limit; saturates instead of wrapping
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RETRY_EXHAUSTED <= 1'b0;
    end else begin
      RETRY_EXHAUSTED <= !CMD_START && (retry_count >= RETRY_LIMIT);
    end
  end

  // Plain fields of the event
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      snap_info_valid <= 1'b0;
      snap_ili        <= 1'b0;
      snap_key        <= '0;
      snap_info       <= '0;
      snap_asc        <= `SSDB_ASC_NONE;
      snap_qual       <= '0;
      snap_unit       <= '0;
    end else if (take_evt) begin
      snap_info_valid <= EVT.info_valid;
      snap_ili        <= EVT.ili;
      snap_key        <= EVT.key;
      snap_info       <= EVT.info_valid ? EVT.info : '0;
      snap_asc        <= enc_asc;
      snap_qual       <= EVT.qualifier;
      snap_unit       <= EVT.replaceable_unit_code;
    end
  end

  // Pointer fields; an invalid pointer is cleared rather than left stale
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pointer_valid_flag     <= 1'b0;
      snap_cd                <= 1'b0;
      bit_pointer_valid_flag <= 1'b0;
      snap_bit_ptr           <= '0;
      snap_field_ptr         <= '0;
    end else if (take_evt) begin
      pointer_valid_flag     <= EVT.ptr_req && (EVT.key == `SSDB_KEY_ILLEGAL);
      snap_cd                <= EVT.ptr_req && (EVT.key == `SSDB_KEY_ILLEGAL) && EVT.cd;
      bit_pointer_valid_flag <= EVT.ptr_req && (EVT.key == `SSDB_KEY_ILLEGAL)
                                && EVT.bit_ptr_req;
      snap_bit_ptr           <= (EVT.ptr_req && (EVT.key == `SSDB_KEY_ILLEGAL)
                                && EVT.bit_ptr_req) ? EVT.bit_ptr : '0;
      snap_field_ptr         <= (EVT.ptr_req && (EVT.key == `SSDB_KEY_ILLEGAL))
                                ? EVT.field_ptr : '0;
    end
  end

  // Retry count is taken at load time, so later retries do not leak in
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      key_specific_valid <= 1'b0;
      snap_retry         <= '0;
    end else if (take_evt) begin
      key_specific_valid <= (EVT.key == `SSDB_KEY_RECOVERED)
                            || (EVT.key == `SSDB_KEY_MEDIUM)
                            || (EVT.key == `SSDB_KEY_HARDWARE);
      snap_retry         <= retry_count;
    end
  end

  assign SENSE_ASC          = snap_asc;
  assign POINTER_VALID_FLAG = pointer_valid_flag;

  // Byte image of the sense block
  function automatic logic [7:0] sense_byte(input logic [4:0] idx);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      `SSDB_IDX_RESP:      b = {snap_info_valid, `SSDB_RESP_CURRENT};
      `SSDB_IDX_KEY:       b = {2'b00, snap_ili, 1'b0, snap_key};
      `SSDB_IDX_INFO0:     b = snap_info[31:24];
      `SSDB_IDX_INFO0 + 5'h01: b = snap_info[23:16];
      `SSDB_IDX_INFO0 + 5'h02: b = snap_info[15:8];
      `SSDB_IDX_INFO3:     b = snap_info[7:0];
      `SSDB_IDX_ADDLEN:    b = `SSDB_ADD_LEN;
      `SSDB_IDX_ASC:       b = snap_asc;
      `SSDB_IDX_QUAL:      b = snap_qual;
      `SSDB_IDX_FRU:       b = snap_unit;
      `SSDB_IDX_KSPEC: begin
        if (pointer_valid_flag) begin
          b = {1'b1, snap_cd, 2'b00, bit_pointer_valid_flag, snap_bit_ptr};
        end else begin
          b = {key_specific_valid, 7'h00};
        end
      end
      `SSDB_IDX_KSPEC_HI: begin
        if (pointer_valid_flag) begin
          b = snap_field_ptr[15:8];
        end else if (key_specific_valid) begin
          b = snap_retry[15:8];
        end
      end
      `SSDB_IDX_KSPEC_LO: begin
        if (pointer_valid_flag) begin
          b = snap_field_ptr[7:0];
        end else if (key_specific_valid) begin
          b = snap_retry[7:0];
        end
      end
      default:             b = 8'h00;
    endcase
    return b;
  endfunction

  assign next_limit = (ALLOC_LEN > {3'b000, `SSDB_SENSE_LEN}) ? `SSDB_SENSE_LEN
                      : ALLOC_LEN[4:0];
  assign next_index = BYTE_OUT.index + 5'h01;

  // Transfer state
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      limit <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (take_req && next_limit != 5'h00) begin
            state <= S_SEND;
            limit <= next_limit;
          end
        end
        S_SEND: begin
          if (advance && BYTE_OUT.last) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BYTE_OUT <= '0;
    end else if (take_req) begin
      BYTE_OUT.data  <= sense_byte(`SSDB_IDX_RESP);
      BYTE_OUT.index <= `SSDB_IDX_RESP;
      BYTE_OUT.last  <= (next_limit == 5'h01);
    end else if (advance && !BYTE_OUT.last) begin
      BYTE_OUT.data  <= sense_byte(next_index);
      BYTE_OUT.index <= next_index;
      BYTE_OUT.last  <= (next_index + 5'h01 == limit);
    end
  end

  // A zero allocation still answers, with no bytes at all
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REQ_DONE <= 1'b0;
    end else begin
      REQ_DONE <= (take_req && next_limit == 5'h00) || (advance && BYTE_OUT.last);
    end
  end

  chk_add_len_fixed: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    BYTE_VALID && BYTE_OUT.index == `SSDB_IDX_ADDLEN |-> BYTE_OUT.data == `SSDB_ADD_LEN)
    else $error("additional sense length not ten");

  chk_reserved_zero: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    BYTE_VALID && BYTE_OUT.index >= `SSDB_IDX_RSV0 && BYTE_OUT.index <= `SSDB_IDX_RSV3
    |-> BYTE_OUT.data == 8'h00)
    else $error("reserved sense byte not zero");

  chk_info_gated: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    BYTE_VALID && !snap_info_valid && BYTE_OUT.index >= `SSDB_IDX_INFO0
    && BYTE_OUT.index <= `SSDB_IDX_INFO3 |-> BYTE_OUT.data == 8'h00)
    else $error("information bytes set while invalid");

  chk_pointer_key: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    pointer_valid_flag |-> snap_key == `SSDB_KEY_ILLEGAL)
    else $error("pointer valid without illegal request");

  chk_pointer_clear: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    !pointer_valid_flag |-> !snap_cd && !bit_pointer_valid_flag && snap_field_ptr == '0)
    else $error("pointer fields left while flag clear");

  chk_bit_pointer: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    take_evt ##1 bit_pointer_valid_flag |-> pointer_valid_flag && $past(EVT.bit_ptr_req))
    else $error("bit pointer valid without cause");

  chk_no_code_one: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    take_evt |=> snap_asc != `SSDB_ASC_RESERVED)
    else $error("reserved sense code reported");

  chk_retry_msb: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    BYTE_VALID && key_specific_valid && !pointer_valid_flag
    && BYTE_OUT.index == `SSDB_IDX_KSPEC_HI |-> BYTE_OUT.data == snap_retry[15:8])
    else $error("retry count high byte misplaced");

  chk_retry_step: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    RETRY_STEP && !CMD_START && retry_count != `SSDB_RETRY_MAX
    |=> retry_count == $past(retry_count) + `SSDB_RETRY_ONE)
    else $error("retry not counted");

  chk_len_limit: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    BYTE_VALID |-> BYTE_OUT.index < limit && limit <= `SSDB_SENSE_LEN)
    else $error("byte beyond allocation");

  chk_done_after: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    advance && BYTE_OUT.last |=> REQ_DONE && !BYTE_VALID)
    else $error("transfer end not signalled");

  chk_cd_capture: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    take_evt && EVT.ptr_req && EVT.key == `SSDB_KEY_ILLEGAL |=> snap_cd == $past(EVT.cd))
    else $error("command or data bit not captured");

  chk_field_ptr_load: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    take_evt && EVT.ptr_req && EVT.key == `SSDB_KEY_ILLEGAL
    |=> snap_field_ptr == $past(EVT.field_ptr))
    else $error("field pointer not captured");

  chk_kspec_byte: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    BYTE_VALID && !pointer_valid_flag && BYTE_OUT.index == `SSDB_IDX_KSPEC
    |-> BYTE_OUT.data == {key_specific_valid, 7'h00})
    else $error("key specific byte wrong");

  chk_qual_kept: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    take_evt |=> snap_qual == $past(EVT.qualifier))
    else $error("qualifier not captured");

  chk_unit_kept: assert property (
    @(posedge REF_CLK) disable iff (!rst_n)
    take_evt |=> snap_unit == $past(EVT.replaceable_unit_code))
    else $error("replaceable unit code not captured");
endmodule
`default_nettype wire

/* File: sim/ssdb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ssdb_host_model (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Control
  input  wire logic               slow,
  input  wire logic               clear,
  // Byte stream
  input  wire logic               byte_valid,
  input  wire ssdb_pkg::ssdb_byte_t byte_in,
  output logic                    byte_ready,
  // Capture
  output logic [7:0]              got [18],
  output logic [4:0]              n_got,
  output logic [4:0]              last_at,
  output logic                    order_bad
);
  import ssdb_pkg::*;
  // Slow mode takes a byte only every other cycle, so the block must hold its output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      byte_ready <= 1'b0;
    else
      byte_ready <= !slow || !byte_ready;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n || clear) begin
      n_got <= 5'h00;
      last_at <= 5'h1f;
      order_bad <= 1'b0;
    end else if (byte_valid && byte_ready) begin
      if (n_got < 5'h12)
        got[n_got] <= byte_in.data;
      if (byte_in.index !== n_got || n_got >= 5'h12)
        order_bad <= 1'b1;
      if (byte_in.last)
        last_at <= n_got;
      n_got <= n_got + 5'h01;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssdb_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_start = 1'b0;
  logic        retry_step = 1'b0;
  logic [15:0] retry_limit = 16'h0000;
  logic        evt_load = 1'b0;
  ssdb_event_t evt = '0;
  logic        req_start = 1'b0;
  logic [7:0]  alloc_len = 8'h00;
  logic        slow = 1'b0;
  logic        clear = 1'b0;
  logic        retry_exh, evt_ready, req_busy, req_done, byte_valid, byte_ready;
  logic        ptr_flag, order_bad;
  ssdb_byte_t  byte_out;
  logic [7:0]  sense_asc;
  logic [7:0]  got [18];
  logic [4:0]  n_got, last_at;
  logic [15:0] rc = 16'h0000;
  int          bad_count = 0;
  int          check_count = 0;

  always #2.5 ref_clk = ~ref_clk;

  ssdb_top uut (.REF_CLK(ref_clk), .RST_N(rst_n), .CMD_START(cmd_start),
    .RETRY_STEP(retry_step), .RETRY_LIMIT(retry_limit), .RETRY_EXHAUSTED(retry_exh),
    .EVT_LOAD(evt_load), .EVT(evt), .EVT_READY(evt_ready), .REQ_START(req_start),
    .ALLOC_LEN(alloc_len), .REQ_BUSY(req_busy), .REQ_DONE(req_done),
    .BYTE_VALID(byte_valid), .BYTE_READY(byte_ready), .BYTE_OUT(byte_out),
    .SENSE_ASC(sense_asc), .POINTER_VALID_FLAG(ptr_flag));

  ssdb_host_model host (.clk(ref_clk), .rst_n(rst_n), .slow(slow), .clear(clear),
    .byte_valid(byte_valid), .byte_in(byte_out), .byte_ready(byte_ready), .got(got),
    .n_got(n_got), .last_at(last_at), .order_bad(order_bad));

  task final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic ssdb_event_t mk(logic [3:0] key, ssdb_cond_t c, logic iv);
    ssdb_event_t e;
    e = '0;
    e.info_valid = iv;
    e.key = key;
    e.info = 32'h1a2b3c4d;
    e.cond = c;
    e.qualifier = 8'h5e;
    e.replaceable_unit_code = 8'h6f;
    return e;
  endfunction

  // Expected sense byte i for event e
  function automatic logic [7:0] xb(ssdb_event_t e, logic [7:0] asc, int i);
    logic p;
    logic s;
    p = e.ptr_req && e.key == 4'h5;
    s = e.key == 4'h1 || e.key == 4'h3 || e.key == 4'h4;
    case (i)
      0: return {e.info_valid, 7'h70};
      2: return {2'b00, e.ili, 1'b0, e.key};
      3, 4, 5, 6: return e.info_valid ? e.info[8*(6-i)+:8] : 8'h00;
      7: return 8'h0a;
      12: return asc;
      13: return e.qualifier;
      14: return e.replaceable_unit_code;
      15: return p ? {1'b1, e.cd, 2'b00, e.bit_ptr_req, e.bit_ptr} : {s, 7'h00};
      16: return p ? e.field_ptr[15:8] : (s ? rc[15:8] : 8'h00);
      17: return p ? e.field_ptr[7:0] : (s ? rc[7:0] : 8'h00);
      default: return 8'h00;
    endcase
  endfunction

  task load(input ssdb_event_t e);
    @(posedge ref_clk);
    evt <= e;
    evt_load <= 1'b1;
    @(posedge ref_clk);
    evt_load <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task req(input logic [7:0] a, input logic [4:0] n, input logic poke);
    int k;
    @(posedge ref_clk);
    clear <= 1'b1;
    req_start <= 1'b1;
    alloc_len <= a;
    if (poke)
      evt.cond <= COND_SYNC_XFER;
    @(posedge ref_clk);
    clear <= 1'b0;
    req_start <= 1'b0;
    for (k = 0; k < 200; k++) begin
      #1;
      if (k == 0)
        chk(req_busy, n != 5'h00);
      if (poke && k == 3)
        chk(evt_ready, 1'b0);
      if (req_done)
        break;
      @(posedge ref_clk);
      evt_load <= poke && k == 2;
    end
    if (k == 200) begin
      bad_count++;
      final_report;
    end else begin
      chk(n_got, n);
      chk(order_bad, 1'b0);
      if (n > 0)
        chk(last_at, n - 5'h01);
    end
  endtask

  task cmp(input ssdb_event_t e, input logic [7:0] asc, input int n);
    for (int i = 0; i < n; i++)
      chk(got[i], xb(e, asc, i));
  endtask

  task automatic t_codes;
    logic [7:0] codes [19] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19,
      8'h1a, 8'h1b};
    for (int k = 0; k < 19; k++) begin
      load(mk(4'h3, ssdb_cond_t'(k), 1'b1));
      chk(sense_asc, codes[k]);
      chk(sense_asc == 8'h01, 1'b0);
    end
    load(mk(4'h3, ssdb_cond_t'(5'h1f), 1'b1));
    chk(sense_asc, 8'h00);
    $display("test codes done");
  endtask

  task automatic t_retry;
    logic [3:0] keys [3] = '{4'h1, 4'h3, 4'h4};
    @(posedge ref_clk);
    retry_limit <= 16'h0001;
    cmd_start <= 1'b1;
    @(posedge ref_clk);
    cmd_start <= 1'b0;
    retry_step <= 1'b1;
    #1;
    chk(retry_exh, 1'b0);
    repeat (5) @(posedge ref_clk);
    retry_step <= 1'b0;
    retry_limit <= 16'h0005;
    rc = 16'h0005;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(retry_exh, 1'b1);
    retry_limit <= 16'h0006;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(retry_exh, 1'b0);
    slow = 1'b1;
    for (int k = 0; k < 3; k++) begin
      load(mk(keys[k], COND_UNRECOV_READ, 1'b1));
      req(8'hff, 5'h12, 1'b1);
      cmp(mk(keys[k], COND_UNRECOV_READ, 1'b1), 8'h11, 18);
      chk(sense_asc, 8'h11);
    end
    slow = 1'b0;
    $display("test retry done");
  endtask

  task t_trunc;
    load(mk(4'h0, COND_NONE, 1'b0));
    req(8'h09, 5'h09, 1'b0);
    cmp(mk(4'h0, COND_NONE, 1'b0), 8'h00, 9);
    req(8'h00, 5'h00, 1'b0);
    $display("test truncation done");
  endtask

  task t_ptr;
    ssdb_event_t e;
    for (int k = 0; k < 3; k++) begin
      e = mk(k == 2 ? 4'h4 : 4'h5, COND_PARAM_LEN, 1'b0);
      e.ptr_req = 1'b1;
      e.cd = k == 0;
      e.ili = k == 1;
      e.bit_ptr_req = 1'b1;
      e.bit_ptr = 3'h6;
      e.field_ptr = k == 0 ? 16'h0007 : 16'h0102;
      load(e);
      chk(ptr_flag, k != 2);
      req(8'h12, 5'h12, 1'b0);
      cmp(e, 8'h1a, 18);
    end
    $display("test pointer done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    chk(req_done, 1'b0);
    chk(byte_valid, 1'b0);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(req_busy, 1'b0);
    chk(evt_ready, 1'b1);
    t_codes;
    t_retry;
    t_trunc;
    t_ptr;
    final_report;
  end
endmodule
`default_nettype wire
